// File: hdl/mcc_pkg.sv
package mcc_pkg;

  // ==========================================================
  // clock and bus
  // ==========================================================
  localparam int CLK_HZ     = 40000000;  // aclk, used as the source clock
  localparam int AXI_ADDR_W = 4;

  // register byte addresses
  localparam logic [3:0] CTRL_STATUS_ADDR = 4'h0;
  localparam logic [3:0] BEEP_CTRL_ADDR   = 4'h4;

  // answers on the bus
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // control/status field positions
  // ==========================================================
  localparam int CS_CLOCK_OUT = 7;
  localparam int CS_PSC_HI    = 6;
  localparam int CS_PSC_LO    = 5;
  localparam int CS_SLOW      = 4;
  localparam int CS_TB_HI     = 3;
  localparam int CS_TB_LO     = 2;
  localparam int CS_OIE       = 1;
  localparam int CS_FLAG      = 0;

  // beep/converter field positions
  localparam int BC_STRETCH = 3;
  localparam int BC_CONV_IE = 2;
  localparam int BC_BEEP_HI = 1;
  localparam int BC_BEEP_LO = 0;
  localparam int BC_W       = 4;          // bits 7:4 read as zero

  localparam logic [7:0]      CTRL_STATUS_RST = 8'h00;
  localparam logic [BC_W-1:0] BEEP_CTRL_RST   = 4'h0;

  // ==========================================================
  // prescaler and time base
  // ==========================================================
  localparam int         PSC_W    = 4;
  localparam logic [3:0] PSC_LAST2  = 4'h1;
  localparam logic [3:0] PSC_LAST4  = 4'h3;
  localparam logic [3:0] PSC_LAST8  = 4'h7;
  localparam logic [3:0] PSC_LAST16 = 4'hf;

  localparam int TB_CNT_W  = 18;
  localparam int TB_PER_00 = 16000;       // source-clock cycles
  localparam int TB_PER_01 = 32000;
  localparam int TB_PER_10 = 80000;
  localparam int TB_PER_11 = 200000;

  // ==========================================================
  // beeper
  // ==========================================================
  localparam int BEEP_HZ_01 = 2000;
  localparam int BEEP_HZ_10 = 1000;
  localparam int BEEP_HZ_11 = 500;
  localparam int BEEP_CNT_W = 16;
  // half period in cycles, rounded down
  localparam int BEEP_HALF_01 = CLK_HZ / (2 * BEEP_HZ_01);
  localparam int BEEP_HALF_10 = CLK_HZ / (2 * BEEP_HZ_10);
  localparam int BEEP_HALF_11 = CLK_HZ / (2 * BEEP_HZ_11);

  // ==========================================================
  // power states
  // ==========================================================
  typedef enum logic [1:0] {
    MCC_RUN         = 2'b00,
    MCC_ACTIVE_HALT = 2'b01,
    MCC_HALT        = 2'b10
  } mcc_state_e;

endpackage

// File: hdl/mcc_beep_gen.sv
module mcc_beep_gen #(
  parameter int HALF_01 = mcc_pkg::BEEP_HALF_01,
  parameter int HALF_10 = mcc_pkg::BEEP_HALF_10,
  parameter int HALF_11 = mcc_pkg::BEEP_HALF_11
) (
  input  wire logic       aclk,     // source clock
  input  wire logic       aresetn,  // sync reset, active low
  input  wire logic [1:0] field,    // beep control field
  input  wire logic       run,      // low freezes the tone
  output logic            tone,     // square wave
  output logic            drive     // pin taken by the beeper
);
  import mcc_pkg::*;

  typedef struct packed {
    logic [BEEP_CNT_W-1:0] cnt;
    logic                  tone;
    logic                  drive;
  } mcc_beep_s;

  mcc_beep_s q;
  mcc_beep_s next_q;

  // ==========================================================
  // half-period lookup
  // ==========================================================
  function automatic logic [BEEP_CNT_W-1:0] half_last(input logic [1:0] f);
    case (f)
      2'b01:   half_last = BEEP_CNT_W'(HALF_01 - 1);
      2'b10:   half_last = BEEP_CNT_W'(HALF_10 - 1);
      default: half_last = BEEP_CNT_W'(HALF_11 - 1);
    endcase
  endfunction

  // ==========================================================
  // tone counter
  // ==========================================================
  // toggle at every half period, giving ~50% duty
  always_comb begin
    next_q       = q;
    next_q.drive = (field != 2'b00);
    if (field == 2'b00) begin
      next_q.cnt  = '0;
      next_q.tone = 1'b0;
    end else if (run) begin
      if (q.cnt >= half_last(field)) begin
        next_q.cnt  = '0;
        next_q.tone = ~q.tone;
      end else begin
        next_q.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tone  = q.tone;
  assign drive = q.drive;

endmodule

// File: hdl/mcc_clock_timebase.sv
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
module mcc_clock_timebase
  import mcc_pkg::*;
#(
  parameter int ADDR_W    = mcc_pkg::AXI_ADDR_W,
  parameter int TB_PER_0  = mcc_pkg::TB_PER_00,
  parameter int TB_PER_1  = mcc_pkg::TB_PER_01,
  parameter int TB_PER_2  = mcc_pkg::TB_PER_10,
  parameter int TB_PER_3  = mcc_pkg::TB_PER_11,
  parameter int BEEP_H_01 = mcc_pkg::BEEP_HALF_01,
  parameter int BEEP_H_10 = mcc_pkg::BEEP_HALF_10,
  parameter int BEEP_H_11 = mcc_pkg::BEEP_HALF_11
) (
  input  wire logic              aclk,                        // source clock
  input  wire logic              aresetn,                     // sync reset, low
  input  wire logic [ADDR_W-1:0] awaddr,                      // write address
  input  wire logic [2:0]        awprot,                      // unused
  input  wire logic              awvalid,                     // write addr valid
  output logic                   awready,                     // write addr ready
  input  wire logic [31:0]       wdata,                       // write data
  input  wire logic [3:0]        wstrb,                       // byte enables
  input  wire logic              wvalid,                      // write data valid
  output logic                   wready,                      // write data ready
  output logic [1:0]             bresp,                       // write answer
  output logic                   bvalid,                      // answer valid
  input  wire logic              bready,                      // answer ready
  input  wire logic [ADDR_W-1:0] araddr,                      // read address
  input  wire logic [2:0]        arprot,                      // unused
  input  wire logic              arvalid,                     // read addr valid
  output logic                   arready,                     // read addr ready
  output logic [31:0]            rdata,                       // read data
  output logic [1:0]             rresp,                       // read answer
  output logic                   rvalid,                      // read data valid
  input  wire logic              rready,                      // read data ready
  input  wire logic              halt_request,                // halt executed
  input  wire logic              wake_interrupt,              // other wake source
  input  wire logic              core_irq_mask,               // core mask active
  output logic                   cpu_clk_en,                  // core clock enable
  output logic                   active_halt,                 // clock-running sleep
  output logic                   full_halt,                   // full-stop sleep
  output logic                   overflow_irq,                // time-base irq
  output logic                   clock_out_pin_o,             // clock out level
  output logic                   clock_out_pin_oe_n,          // low: driving
  output logic                   tone_output_pin_o,           // tone level
  output logic                   tone_output_pin_oe_n,        // low: driving
  output logic                   sample_time_stretch_enable,  // converter stretch
  output logic                   converter_interrupt_enable   // converter irq gate
);
  import mcc_pkg::*;

  typedef struct packed {
    mcc_state_e            st;
    logic [7:0]            cs;       // control/status
    logic [BC_W-1:0]       bc;       // beep and converter
    logic [1:0]            tb_run;   // time base of period in progress
    logic [TB_CNT_W-1:0]   tb_cnt;
    logic [PSC_W-1:0]      psc_cnt;
    logic                  cpu_en;
    logic                  co;       // clock-out level
    logic                  aw_got;
    logic [ADDR_W-1:0]     aw_addr;
    logic                  w_got;
    logic [7:0]            w_byte;
    logic                  w_lane0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [7:0]            rdata;
    logic [1:0]            rresp;
  } mcc_state_s;

  mcc_state_s q;
  mcc_state_s next_q;
  logic       beep_tone;
  logic       beep_drive;

  // ==========================================================
  // helper functions
  // ==========================================================
  function automatic logic [PSC_W-1:0] psc_last(input logic [1:0] code);
    case (code)
      2'b00:   psc_last = PSC_LAST2;
      2'b01:   psc_last = PSC_LAST4;
      2'b10:   psc_last = PSC_LAST8;
      default: psc_last = PSC_LAST16;
    endcase
  endfunction

  function automatic logic [TB_CNT_W-1:0] tb_last(input logic [1:0] code);
    case (code)
      2'b00:   tb_last = TB_CNT_W'(TB_PER_0 - 1);
      2'b01:   tb_last = TB_CNT_W'(TB_PER_1 - 1);
      2'b10:   tb_last = TB_CNT_W'(TB_PER_2 - 1);
      default: tb_last = TB_CNT_W'(TB_PER_3 - 1);
    endcase
  endfunction

  // word decode: low two bits ignored, rest must match
  function automatic logic hits(input logic [ADDR_W-1:0] a,
                                input logic [3:0]        reg_addr);
    hits = (a[ADDR_W-1:2] == reg_addr[ADDR_W-1:2]);
  endfunction

  // ==========================================================
  // next-state logic
  // ==========================================================
  always_comb begin
    logic running;
    logic counting;
    logic wrap;
    logic ovf_set;
    logic ovf_clr;
    logic wr_go;
    logic rd_go;
    running  = 1'b0;
    counting = 1'b0;
    wrap     = 1'b0;
    ovf_set  = 1'b0;
    ovf_clr  = 1'b0;
    wr_go    = 1'b0;
    rd_go    = 1'b0;
    next_q   = q;

    running = (q.st == MCC_RUN);
    counting = (q.st != MCC_HALT);

    // --------------------------------------------------------
    // time base; counts regardless of prescaler or clock out
    // --------------------------------------------------------
    // independent functions
    if (counting) begin
      if (q.tb_cnt >= tb_last(q.tb_run)) begin
        wrap        = 1'b1;
        next_q.tb_cnt = '0;
        next_q.tb_run = q.cs[CS_TB_HI:CS_TB_LO];
      end else begin
        next_q.tb_cnt = q.tb_cnt + 1'b1;
      end
    end
    ovf_set = wrap;

    // --------------------------------------------------------
    // prescaler: one-cycle core enable per divided period
    // --------------------------------------------------------
    if (!running) begin
      next_q.cpu_en  = 1'b0;
      next_q.psc_cnt = '0;
    end else if (!q.cs[CS_SLOW]) begin
      next_q.cpu_en  = 1'b1;
      next_q.psc_cnt = '0;
    end else begin
      if (q.psc_cnt >= psc_last(q.cs[CS_PSC_HI:CS_PSC_LO])) begin
        next_q.psc_cnt = '0;
        next_q.cpu_en  = 1'b1;
      end else begin
        next_q.psc_cnt = q.psc_cnt + 1'b1;
        next_q.cpu_en  = 1'b0;
      end
    end

    // source clock image; halts stop the oscillator output
    next_q.co = running ? ~q.co : 1'b0;

    // --------------------------------------------------------
    // write channel: address and data taken in either order
    // --------------------------------------------------------
    if (awvalid && awready) begin
      next_q.aw_got  = 1'b1;
      next_q.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_q.w_got   = 1'b1;
      next_q.w_byte  = wdata[7:0];
      next_q.w_lane0 = wstrb[0];
    end
    if (q.bvalid && bready) begin
      next_q.bvalid = 1'b0;
    end
    wr_go = q.aw_got && q.w_got && !q.bvalid;
    if (wr_go) begin
      next_q.aw_got = 1'b0;
      next_q.w_got  = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp  = RESP_OKAY;
      if (hits(q.aw_addr, CTRL_STATUS_ADDR)) begin
        if (q.w_lane0 && running) begin
          next_q.cs[7:1] = q.w_byte[7:1];
        end
      end else if (hits(q.aw_addr, BEEP_CTRL_ADDR)) begin
        if (q.w_lane0 && running) begin
          next_q.bc = q.w_byte[BC_W-1:0];
        end
      end else begin
        next_q.bresp = RESP_SLVERR;
      end
    end

    // --------------------------------------------------------
    // read channel
    // --------------------------------------------------------
    if (q.rvalid && rready) begin
      next_q.rvalid = 1'b0;
    end
    rd_go = arvalid && arready;
    if (rd_go) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = RESP_OKAY;
      if (hits(araddr, CTRL_STATUS_ADDR)) begin
        next_q.rdata = q.cs;
        ovf_clr = running;
      end else if (hits(araddr, BEEP_CTRL_ADDR)) begin
        next_q.rdata = {{(8 - BC_W){1'b0}}, q.bc};
      end else begin
        next_q.rdata = '0;
        next_q.rresp = RESP_SLVERR;
      end
    end

    // an overflow in the clearing cycle survives the read
    next_q.cs[CS_FLAG] = ovf_set | (q.cs[CS_FLAG] & ~ovf_clr);

    // --------------------------------------------------------
    // power states
    // --------------------------------------------------------
    case (q.st)
      MCC_RUN: begin
        if (halt_request) begin
          next_q.st = q.cs[CS_OIE] ? MCC_ACTIVE_HALT : MCC_HALT;
        end
      end
      MCC_ACTIVE_HALT: begin
        if ((q.cs[CS_FLAG] && q.cs[CS_OIE]) || wake_interrupt) begin
          next_q.st = MCC_RUN;
        end
      end
      MCC_HALT: begin
        if (wake_interrupt) begin
          next_q.st = MCC_RUN;
        end
      end
      default: begin
        next_q.st = MCC_RUN;
      end
    endcase
  end

  // ==========================================================
  // state register
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.st      <= MCC_RUN;
      q.cs      <= CTRL_STATUS_RST;
      q.bc      <= BEEP_CTRL_RST;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // beeper
  // ==========================================================
  // full-stop sleep halts the oscillator, so the tone freezes too
  mcc_beep_gen #(
    .HALF_01 (BEEP_H_01),
    .HALF_10 (BEEP_H_10),
    .HALF_11 (BEEP_H_11)
  ) u_beep (
    .aclk    (aclk),
    .aresetn (aresetn),
    .field   (q.bc[BC_BEEP_HI:BC_BEEP_LO]),
    .run     (q.st != MCC_HALT),
    .tone    (beep_tone),
    .drive   (beep_drive)
  );

  // ==========================================================
  // outputs
  // ==========================================================
  // bus handshakes; one write and one read in flight
  assign awready = !q.aw_got && !q.bvalid;
  assign wready  = !q.w_got && !q.bvalid;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = !q.rvalid;
  assign rvalid  = q.rvalid;
  assign rresp   = q.rresp;
  assign rdata   = {24'h000000, q.rdata};

  assign cpu_clk_en  = q.cpu_en;
  assign active_halt = (q.st == MCC_ACTIVE_HALT);
  assign full_halt   = (q.st == MCC_HALT);

  assign overflow_irq = q.cs[CS_FLAG] && q.cs[CS_OIE] && !core_irq_mask;

  assign clock_out_pin_o    = q.co;
  assign clock_out_pin_oe_n = !(q.cs[CS_CLOCK_OUT] && (q.st == MCC_RUN));

  assign tone_output_pin_o    = beep_tone;
  assign tone_output_pin_oe_n = !beep_drive;

  assign sample_time_stretch_enable = q.bc[BC_STRETCH];
  assign converter_interrupt_enable = q.bc[BC_CONV_IE];

endmodule

// File: testbench/mcc_clock_timebase_chk.sv
module mcc_clock_timebase_chk (
  input wire logic aclk,               // source clock
  input wire logic aresetn,            // sync reset, low
  input wire logic halt_request,       // halt executed
  input wire logic wake_interrupt,     // other wake source
  input wire logic core_irq_mask,      // core mask active
  input wire logic cpu_clk_en,         // core clock enable
  input wire logic active_halt,        // clock-running sleep
  input wire logic full_halt,          // full-stop sleep
  input wire logic overflow_irq,       // time-base irq
  input wire logic clock_out_pin_o,    // clock out level
  input wire logic clock_out_pin_oe_n  // low: driving
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // helper logic
  // ==========================================================
  logic [4:0] zero_run;

  // silent core cycles while running; one spare cycle covers a prescaler restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_run <= 5'h00;
    end else if (!cpu_clk_en && !active_halt && !full_halt) begin
      zero_run <= zero_run + 5'h01;
    end else begin
      zero_run <= 5'h00;
    end
  end

  // ==========================================================
  // properties
  // ==========================================================
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_prescale;
    zero_run <= 5'h10;
  endproperty
  property p_halt_entry;
    halt_request && !active_halt && !full_halt |=> active_halt || full_halt;
  endproperty
  property p_active_wake;
    active_halt && overflow_irq |=> !active_halt;
  endproperty
  property p_full_stay;
    full_halt && !wake_interrupt |=> full_halt;
  endproperty
  property p_full_wake;
    full_halt && wake_interrupt |=> !full_halt;
  endproperty
  property p_mask;
    core_irq_mask |-> !overflow_irq;
  endproperty
  property p_clkout_susp;
    active_halt ##1 active_halt |-> clock_out_pin_oe_n && !clock_out_pin_o;
  endproperty
  property p_clkout_tog;
    !clock_out_pin_oe_n ##1 !clock_out_pin_oe_n |-> clock_out_pin_o != $past(clock_out_pin_o);
  endproperty
  property p_core_gate;
    (active_halt || full_halt) ##1 (active_halt || full_halt) |-> !cpu_clk_en;
  endproperty

  a_prescale: assert property (p_prescale)
    else $error("core clock silent too long");
  a_halt_entry: assert property (p_halt_entry)
    else $error("halt did not enter a sleep state");
  a_active_wake: assert property (p_active_wake)
    else $error("overflow did not wake clock-running sleep");
  a_full_stay: assert property (p_full_stay)
    else $error("full-stop sleep left without wake source");
  a_full_wake: assert property (p_full_wake)
    else $error("wake source did not end full-stop sleep");
  a_mask: assert property (p_mask)
    else $error("overflow irq raised while core mask active");
  a_clkout_susp: assert property (p_clkout_susp)
    else $error("clock out not suspended in sleep");
  a_clkout_tog: assert property (p_clkout_tog)
    else $error("clock out not toggling while driven");
  a_core_gate: assert property (p_core_gate)
    else $error("core clock running in sleep");

  c_active: cover property (active_halt ##1 !active_halt);
  c_full: cover property ($rose(full_halt));
  c_slow16: cover property (zero_run == 5'h0f);
endmodule

bind mcc_clock_timebase mcc_clock_timebase_chk mcc_clock_timebase_chk_inst (
  .aclk(aclk),
  .aresetn(aresetn),
  .halt_request(halt_request),
  .wake_interrupt(wake_interrupt),
  .core_irq_mask(core_irq_mask),
  .cpu_clk_en(cpu_clk_en),
  .active_halt(active_halt),
  .full_halt(full_halt),
  .overflow_irq(overflow_irq),
  .clock_out_pin_o(clock_out_pin_o),
  .clock_out_pin_oe_n(clock_out_pin_oe_n)
);

// File: testbench/mcc_core_model.sv
module mcc_core_model (
  input  wire logic aclk,            // source clock
  input  wire logic aresetn,         // sync reset, low
  input  wire logic cpu_clk_en,      // core clock enable
  input  wire logic halt_cmd,        // bench asks for a halt
  input  wire logic wake_cmd,        // bench asks for a wake
  output logic      halt_request,    // halt executed
  output logic      wake_interrupt,  // other wake source
  output int        ticks            // core clocks seen
);
  timeunit 1ns;
  timeprecision 100ps;

  // core counts its own clocks; halt and wake come one cycle after the command
  always @(posedge aclk) begin
    if (!aresetn) begin
      halt_request <= 1'b0;
      wake_interrupt <= 1'b0;
      ticks <= 0;
    end else begin
      halt_request <= halt_cmd;
      wake_interrupt <= wake_cmd;
      if (cpu_clk_en) begin
        ticks <= ticks + 1;
      end
    end
  end
endmodule

// File: testbench/tb_top.sv
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
  import mcc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // signals
  // ==========================================================
  localparam int TP [4] = '{16, 32, 80, 200};
  localparam int BH [4] = '{0, 4, 8, 16};
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic halt_cmd = 0, wake_cmd = 0, mask = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] rd_d;
  logic awready, wready, bvalid, arready, rvalid, halt_request, wake_interrupt;
  logic cpu_clk_en, active_halt, full_halt, overflow_irq, clock_out_pin_o;
  logic clock_out_pin_oe_n, tone_output_pin_o, tone_output_pin_oe_n;
  logic sample_time_stretch_enable, converter_interrupt_enable;
  int failures = 0, n_compared = 0, cyc = 0, ticks, t, t0, t1;

  // short periods keep the run brief
  mcc_clock_timebase #(.TB_PER_0(TP[0]), .TB_PER_1(TP[1]), .TB_PER_2(TP[2]),
    .TB_PER_3(TP[3]), .BEEP_H_01(BH[1]), .BEEP_H_10(BH[2]), .BEEP_H_11(BH[3]))
  mcc_clock_timebase_inst (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready(1'b1),
    .halt_request, .wake_interrupt, .core_irq_mask(mask), .cpu_clk_en, .active_halt,
    .full_halt, .overflow_irq, .clock_out_pin_o, .clock_out_pin_oe_n, .tone_output_pin_o,
    .tone_output_pin_oe_n, .sample_time_stretch_enable, .converter_interrupt_enable);

  mcc_core_model mcc_core_model_inst (.aclk, .aresetn, .cpu_clk_en, .halt_cmd, .wake_cmd,
    .halt_request, .wake_interrupt, .ticks);

  // clock and a free cycle count for period measurements
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // ==========================================================
  // bus and measurement tasks
  // ==========================================================
  // ready lines stay high, so no release ever races a following request
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_d = rdata[7:0];
    rsp = rresp;
  endtask

  task automatic wait_irq(output int at);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (overflow_irq !== 1'b1 && n < 1000);
    at = cyc;
  endtask

  task automatic wait_tone(output int at);
    logic v;
    int n;
    v = tone_output_pin_o;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (tone_output_pin_o === v && n < 100);
    at = cyc;
  endtask

  task automatic pulse_core(input logic wake);
    if (wake) wake_cmd <= 1'b1;
    else halt_cmd <= 1'b1;
    @(posedge aclk);
    wake_cmd <= 1'b0;
    halt_cmd <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog: the sequence needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    tally_and_finish;
  end

  // ==========================================================
  // test sequence
  // ==========================================================
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0); `CHK("ctrl reset", 8'h00, rd_d)
    rd(4'h4); `CHK("beep reset", 8'h00, rd_d)
    rd(4'h8); `CHK("unmapped resp", RESP_SLVERR, rsp)
    wr(4'h4, 8'h0c);
    `CHK("stretch on", 1'b1, sample_time_stretch_enable)
    `CHK("conv irq on", 1'b1, converter_interrupt_enable)
    wr(4'h4, 8'h04);
    `CHK("stretch off", 1'b0, sample_time_stretch_enable)
    rd(4'h4); `CHK("beep readback", 8'h04, rd_d)
    // every prescaler code with clock out driven at the same time
    for (int k = 0; k < 5; k++) begin
      wr(4'h0, (k < 4) ? {1'b1, 2'(k), 5'h10} : 8'h00);
      repeat (20) @(posedge aclk);
      t = ticks;
      repeat (64) @(posedge aclk);
      `CHK("core ticks", (k < 4) ? (64 >> (k + 1)) : 64, ticks - t)
      `CHK("clock out oe", (k < 4) ? 1'b0 : 1'b1, clock_out_pin_oe_n)
    end
    // each time base measured between two overflows
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, {4'h0, 2'(k), 2'b10});
      rd(4'h0);
      // the first overflow may meet the clearing read, so measure from the next one
      wait_irq(t0);
      rd(4'h0);
      wait_irq(t0);
      rd(4'h0);
      wait_irq(t1);
      `CHK("period", TP[k], t1 - t0)
    end
    rd(4'h0); `CHK("flag set", 1'b1, rd_d[0])
    rd(4'h0); `CHK("flag cleared", 1'b0, rd_d[0])
    wr(4'h0, 8'h0f);
    rd(4'h0); `CHK("flag not written", 8'h0e, rd_d)
    mask <= 1'b1;
    repeat (210) @(posedge aclk);
    `CHK("irq masked", 1'b0, overflow_irq)
    mask <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK("irq unmasked", 1'b1, overflow_irq)
    // clock-running sleep with clock out enabled
    wr(4'h0, 8'h8e);
    rd(4'h0);
    t = cyc;
    pulse_core(1'b0);
    `CHK("active halt", 1'b1, active_halt)
    `CHK("clock out held", 1'b1, clock_out_pin_oe_n)
    wait_irq(t0);
    repeat (2) @(posedge aclk);
    `CHK("overflow wake", 1'b0, active_halt)
    `CHK("wake in time", 1'b1, t0 - t <= TP[3])
    // full-stop sleep ignores writes and the time base
    rd(4'h0);
    wr(4'h0, 8'h8c);
    pulse_core(1'b0);
    `CHK("full halt", 1'b1, full_halt)
    wr(4'h4, 8'h08);
    repeat (450) @(posedge aclk);
    `CHK("still halted", 1'b1, full_halt)
    pulse_core(1'b1);
    `CHK("woken", 1'b0, full_halt)
    rd(4'h4); `CHK("frozen beep", 8'h04, rd_d)
    // new time base waits for the running period to end; irq needs its enable back
    wr(4'h0, 8'h0e);
    rd(4'h0);
    wait_irq(t0);
    rd(4'h0);
    wait_irq(t0);
    wr(4'h0, 8'h02);
    rd(4'h0);
    wait_irq(t1);
    `CHK("old period kept", TP[3], t1 - t0)
    // tones in rising order so the half-period counter never overshoots
    for (int k = 1; k < 4; k++) begin
      wr(4'h4, {6'h01, 2'(k)});
      wait_tone(t0);
      wait_tone(t1);
      `CHK("tone half period", BH[k], t1 - t0)
      `CHK("tone driven", 1'b0, tone_output_pin_oe_n)
    end
    wr(4'h4, 8'h04);
    `CHK("tone released", 1'b1, tone_output_pin_oe_n)
    tally_and_finish;
  end
endmodule
